// >>> rtl/dci_params.svh
// constants for the command/address/clock-enable front end
// assumes inclusion by the package and the design modules
`ifndef DCI_PARAMS_SVH
`define DCI_PARAMS_SVH
`define DCI_ADDR_W 14
`define DCI_BANK_W 2
`define DCI_MRSEL_W 3
`define DCI_NUM_BANKS 4
`define DCI_AP_BIT 10
`define DCI_SYNC_STAGES 3
`endif

// >>> rtl/dci_pkg.sv
// types shared by the command/address front end
// assumes the params header sits beside it
`include "dci_params.svh"
package dci_pkg;
	typedef enum logic [3:0] {
		DCI_CMD_NOP,
		DCI_CMD_ACT,
		DCI_CMD_RD,
		DCI_CMD_WR,
		DCI_CMD_PRE,
		DCI_CMD_LMR,
		DCI_CMD_REF,
		DCI_CMD_SREF,
		DCI_CMD_DESEL
	} dci_cmd_t;
	typedef enum logic [2:0] {
		DCI_PW_ACTIVE,
		DCI_PW_PRE_PD,
		DCI_PW_ACT_PD,
		DCI_PW_SELF_REF
	} dci_pwr_t;
	// pins sampled at a rising crossing that carries a selected command or an enable change
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic [`DCI_MRSEL_W-1:0] ba;
		logic [`DCI_ADDR_W-1:0] addr;
	} dci_pins_t;
	// decoded command handed to the core side
	typedef struct packed {
		dci_cmd_t cmd;
		logic [`DCI_MRSEL_W-1:0] ba;
		logic [`DCI_ADDR_W-1:0] addr;
		logic auto_pre;
		logic all_banks;
	} dci_req_t;
endpackage

// >>> rtl/dci_sync.sv
// three-stage synchroniser with agreement filter for one level
// assumes a single destination clock
`timescale 1ns/1ps
module dci_sync
	import dci_pkg::*;
#(
	parameter int STAGES = `DCI_SYNC_STAGES
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic din,
	output logic dout
);
	initial
	begin
		if (STAGES != 3)
			$error("dci_sync: only three stages supported");
	end
	logic s1_q, s2_q, s3_q, out_q;
	logic s1_d, s2_d, s3_d, out_d;
	// ======================================
	// next values: change counts once stages two and three agree
	always_comb
	begin
		s1_d = din;
		s2_d = s1_q;
		s3_d = s2_q;
		out_d = (s2_q == s3_q) ? s3_q : out_q;
	end
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			out_q <= 1'b0;
		end
		else
		begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			out_q <= out_d;
		end
	end
	assign dout = out_q;
endmodule

// >>> rtl/dci_front.sv
// command, address and clock-enable capture of a four-bank DRAM
// assumes ck is the true clock pin; ck_n is its complement and
// every rising edge of ck is the positive crossing; core side on clk
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] activate takes address pins as the row to open
// [RULE_02] read/write take column from address; bit 10 flags auto precharge
// [RULE_03] precharge closes addressed bank if bit 10 low, all if high
// [RULE_04] load mode takes address pins as the mode register opcode
// [RULE_05] two bank bits pick the bank for bank commands
// [RULE_06] bank bits pick base or one of three extended mode registers
// [RULE_07] inputs sampled where true clock rises and complement falls
// [RULE_08] output data and strobes timed from clock crossings
// [RULE_09] clock enable high runs internal clocking, low stops it
// [RULE_10] enable low: idle banks give precharge down or self refresh
// [RULE_11] enable sampled on clock for power-down and self-refresh entry
// [RULE_12] self-refresh exit on enable rise needs no running clock
// [RULE_13] power-down keeps only clocks, enable and termination receivers
// [RULE_14] self refresh keeps only the enable receiver
// [RULE_15] chip select high masks every command
// [RULE_16] row, column, write strobes and select encode the command
// [RULE_17] controller sizes address: 13 bits x16, 14 bits x4/x8
module dci_front
	import dci_pkg::*;
#(
	parameter int ADDR_W = `DCI_ADDR_W
)
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ck,
	input wire logic ck_n,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic termination_ctl,
	input wire logic [`DCI_MRSEL_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	output dci_req_t req,
	output logic req_valid,
	output logic [`DCI_ADDR_W-1:0] open_row [`DCI_NUM_BANKS],
	output logic [`DCI_NUM_BANKS-1:0] bank_open,
	output logic [`DCI_ADDR_W-1:0] base_mode_reg,
	output logic [`DCI_ADDR_W-1:0] ext_mode_reg_1,
	output logic [`DCI_ADDR_W-1:0] ext_mode_reg_2,
	output logic [`DCI_ADDR_W-1:0] ext_mode_reg_3,
	output dci_pwr_t pwr_state,
	output logic clocking_on,
	output logic cmd_rx_en,
	output logic clk_rx_en,
	output logic term_rx_en,
	output logic out_clk
);
	initial
	begin
		if (ADDR_W < 13 || ADDR_W > `DCI_ADDR_W)
			$error("dci_front: address width must be 13 or 14");
	end

	// ======================================
	// link domain: capture at the positive crossing
	// power-up values stand in for a reset; ck may not run during srst
	dci_pins_t pins_q = '1;
	dci_pins_t pins_d;
	logic ev_tgl_q = 1'b0;
	logic ev_tgl_d;
	logic cke_prev_q = 1'b1;
	logic cke_prev_d;
	logic [ADDR_W-1:0] addr_gated;
	logic rx_gate;

	// receivers gated per power state; enable pin never gated
	assign rx_gate = cmd_rx_en;
	assign addr_gated = rx_gate ? addr : '0;

	always_comb
	begin
		pins_d = pins_q;
		ev_tgl_d = ev_tgl_q;
		cke_prev_d = cke;
		// capture and flag only when something needs the core, so the
		// word stays put while the core side reads it
		if ((rx_gate && !cs_n) || (cke != cke_prev_q))
		begin
			ev_tgl_d = ~ev_tgl_q;
			// sample every pin at the rising crossing, see [RULE_07]
			pins_d.cke = cke;
			pins_d.cs_n = rx_gate ? cs_n : 1'b1; // receivers off: deselect
			pins_d.ras_n = ras_n;
			pins_d.cas_n = cas_n;
			pins_d.we_n = we_n;
			pins_d.ba = ba;
			pins_d.addr = `DCI_ADDR_W'(addr_gated);
		end
	end

	// link clock may stop; registers start from power-up values
	always_ff @(posedge ck)
	begin
		pins_q <= pins_d;
		ev_tgl_q <= ev_tgl_d;
		cke_prev_q <= cke_prev_d;
	end
	assign out_clk = ck & ~ck_n; // output timing reference, see [RULE_08]

	// ======================================
	// crossing: toggle event plus held word, enable pin separately
	logic ev_sync, cke_sync;
	dci_sync u_ev_sync
	(
		.clk(clk),
		.srst(srst),
		.din(ev_tgl_q),
		.dout(ev_sync)
	);
	// async enable path lets self-refresh exit without ck, see [RULE_12]
	dci_sync u_cke_sync
	(
		.clk(clk),
		.srst(srst),
		.din(cke),
		.dout(cke_sync)
	);

	// ======================================
	// core domain: decode, bank state, mode registers, power
	logic ev_seen_q, ev_seen_d;
	dci_req_t req_q, req_d;
	logic req_valid_q, req_valid_d;
	logic [`DCI_ADDR_W-1:0] row_q [`DCI_NUM_BANKS];
	logic [`DCI_ADDR_W-1:0] row_d [`DCI_NUM_BANKS];
	logic [`DCI_NUM_BANKS-1:0] open_q, open_d;
	logic [`DCI_ADDR_W-1:0] mr_q [4];
	logic [`DCI_ADDR_W-1:0] mr_d [4];
	dci_pwr_t pwr_q, pwr_d;
	dci_cmd_t cmd;
	logic new_ev;
	logic [`DCI_BANK_W-1:0] bank;

	assign new_ev = ev_sync != ev_seen_q;
	assign bank = pins_q.ba[`DCI_BANK_W-1:0]; // see [RULE_05]

	// command decode from strobes and select
	always_comb
	begin
		cmd = DCI_CMD_NOP;
		if (pins_q.cs_n)
			cmd = DCI_CMD_DESEL; // masked, see [RULE_15]
		else
		begin
			unique case ({pins_q.ras_n, pins_q.cas_n, pins_q.we_n})
				3'h3: cmd = DCI_CMD_ACT; // see [RULE_16]
				3'h5: cmd = DCI_CMD_RD;
				3'h4: cmd = DCI_CMD_WR;
				3'h2: cmd = DCI_CMD_PRE;
				3'h0: cmd = DCI_CMD_LMR;
				3'h1: cmd = pins_q.cke ? DCI_CMD_REF : DCI_CMD_SREF;
				default: cmd = DCI_CMD_NOP;
			endcase
		end
	end

	always_comb
	begin
		ev_seen_d = ev_sync;
		req_d = req_q;
		req_valid_d = 1'b0;
		row_d = row_q;
		open_d = open_q;
		mr_d = mr_q;
		pwr_d = pwr_q;
		if (new_ev && pwr_q != DCI_PW_SELF_REF)
		begin
			req_d.cmd = cmd;
			req_d.ba = pins_q.ba;
			req_d.addr = pins_q.addr;
			req_d.auto_pre = 1'b0;
			req_d.all_banks = 1'b0;
			req_valid_d = (cmd != DCI_CMD_DESEL) && (cmd != DCI_CMD_NOP);
			unique case (cmd)
				DCI_CMD_ACT:
				begin
					row_d[bank] = pins_q.addr; // see [RULE_01]
					open_d[bank] = 1'b1;
				end
				DCI_CMD_RD, DCI_CMD_WR:
				begin
					// column plus auto precharge flag, see [RULE_02]
					req_d.auto_pre = pins_q.addr[`DCI_AP_BIT];
					if (pins_q.addr[`DCI_AP_BIT])
						open_d[bank] = 1'b0;
				end
				DCI_CMD_PRE:
				begin
					// one bank or all, see [RULE_03]
					req_d.all_banks = pins_q.addr[`DCI_AP_BIT];
					if (pins_q.addr[`DCI_AP_BIT])
						open_d = '0;
					else
						open_d[bank] = 1'b0;
				end
				DCI_CMD_LMR:
				begin
					// opcode into register chosen by bank bits
					if (pins_q.ba[`DCI_MRSEL_W-1] == 1'b0)
						mr_d[bank] = pins_q.addr; // see [RULE_04] [RULE_06]
				end
				DCI_CMD_SREF:
					pwr_d = DCI_PW_SELF_REF; // see [RULE_10]
				default:
				begin
				end
			endcase
		end
		// enable sampled on the clock for entry and power-down exit, see [RULE_11]
		unique case (pwr_q)
			DCI_PW_ACTIVE:
				if (new_ev && !pins_q.cke && cmd != DCI_CMD_SREF)
					pwr_d = (open_q != '0) ? DCI_PW_ACT_PD : DCI_PW_PRE_PD;
			DCI_PW_PRE_PD, DCI_PW_ACT_PD:
				if (new_ev && pins_q.cke)
					pwr_d = DCI_PW_ACTIVE;
			DCI_PW_SELF_REF:
				if (cke_sync)
					pwr_d = DCI_PW_ACTIVE; // see [RULE_12]
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ev_seen_q <= 1'b0;
			req_q <= '0;
			req_valid_q <= 1'b0;
			row_q <= '{default: '0};
			open_q <= '0;
			mr_q <= '{default: '0};
			pwr_q <= DCI_PW_ACTIVE;
		end
		else
		begin
			ev_seen_q <= ev_seen_d;
			req_q <= req_d;
			req_valid_q <= req_valid_d;
			row_q <= row_d;
			open_q <= open_d;
			mr_q <= mr_d;
			pwr_q <= pwr_d;
		end
	end

	// ======================================
	// outputs and receiver enables
	assign req = req_q;
	assign req_valid = req_valid_q;
	assign open_row = row_q;
	assign bank_open = open_q;
	assign base_mode_reg = mr_q[0];
	assign ext_mode_reg_1 = mr_q[1];
	assign ext_mode_reg_2 = mr_q[2];
	assign ext_mode_reg_3 = mr_q[3];
	assign pwr_state = pwr_q;
	assign clocking_on = pwr_q == DCI_PW_ACTIVE; // see [RULE_09]
	// command receivers off in any low-power state, see [RULE_13]
	assign cmd_rx_en = pwr_q == DCI_PW_ACTIVE;
	// clock receiver off only in self refresh; termination off in self refresh or when termination_ctl low
	assign clk_rx_en = pwr_q != DCI_PW_SELF_REF; // see [RULE_14]
	assign term_rx_en = (pwr_q != DCI_PW_SELF_REF) & termination_ctl;
endmodule

// >>> verif/dci_front_asserts.sv
// checker for the command front end
// assumes a bind onto dci_front, core clock domain
`timescale 1ns/1ps
module dci_front_asserts
	import dci_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic cke,
	input wire logic termination_ctl,
	input wire dci_req_t req,
	input wire logic req_valid,
	input wire logic [13:0] open_row [4],
	input wire logic [3:0] bank_open,
	input wire dci_pwr_t pwr_state,
	input wire logic cmd_rx_en,
	input wire logic clk_rx_en,
	input wire logic term_rx_en
);
	// ==========
	// checks
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// enable held high long enough to pass the synchroniser
	sequence cke_held;
		cke [*8];
	endsequence
	AST_ROW: assert property (
		req_valid && req.cmd == DCI_CMD_ACT |-> bank_open[req.ba[1:0]]
		&& open_row[req.ba[1:0]] == req.addr) else $error("row");
	AST_AP: assert property (
		req_valid && req.cmd inside {DCI_CMD_RD, DCI_CMD_WR}
		|-> req.auto_pre == req.addr[10]) else $error("auto pre");
	AST_PRE: assert property (
		req_valid && req.cmd == DCI_CMD_PRE |-> req.all_banks ==
		req.addr[10] && (!req.all_banks || bank_open == 0)) else $error("pre");
	AST_RUN: assert property (
		pwr_state == DCI_PW_ACTIVE |-> cmd_rx_en && clk_rx_en)
		else $error("run");
	AST_PD: assert property (
		pwr_state inside {DCI_PW_PRE_PD, DCI_PW_ACT_PD}
		|-> !cmd_rx_en && clk_rx_en) else $error("pd rx");
	AST_SR: assert property (
		pwr_state == DCI_PW_SELF_REF |-> !cmd_rx_en && !clk_rx_en)
		else $error("sr rx");
	AST_TERM: assert property (
		term_rx_en == (clk_rx_en && termination_ctl)) else $error("term");
	AST_WAKE: assert property (
		cke_held |-> pwr_state != DCI_PW_SELF_REF) else $error("wake");
endmodule
bind dci_front dci_front_asserts chk (.clk, .srst, .cke, .termination_ctl,
	.req, .req_valid, .open_row, .bank_open, .pwr_state, .cmd_rx_en,
	.clk_rx_en, .term_rx_en);

// >>> verif/dci_ctl_model.sv
// controller model driving the clock pair and command pins
// assumes send is called between core clock edges
`timescale 1ns/1ps
module dci_ctl_model
	import dci_pkg::*;
(
	output logic ck,
	output logic ck_n,
	output dci_pins_t p
);
	// ==========
	// clock stands low between frames
	initial
	begin
		ck = 1'b0;
		p = '1;
	end
	// enable level applied at the command edge of the next frame
	logic cke_cmd = 1'b1;
	assign ck_n = ~ck;
	// two idle edges, the command edge, one idle edge
	task automatic send(input logic [3:0] c, input logic [2:0] b,
		input logic [13:0] a);
		for (int i = 0; i < 4; i++)
		begin
			{p.cs_n, p.ras_n, p.cas_n, p.we_n} = (i == 2) ? c : 4'hf;
			p.ba = (i == 2) ? b : ~b;
			p.addr = (i == 2) ? a : ~a;
			if (i == 2)
				p.cke = cke_cmd;
			#3 ck = 1'b1;
			#3 ck = 1'b0;
		end
	endtask
endmodule

// >>> verif/dci_front_bench.sv
// bench for the command front end against a reference model
// assumes the controller model and the checker bind
`timescale 1ns/1ps
module dci_front_bench
	import dci_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ck;
	logic ck_n;
	logic tctl = 1'b0;
	logic req_valid;
	logic [3:0] bank_open;
	logic [13:0] open_row [4];
	logic [13:0] mr [4];
	dci_pins_t p;
	dci_req_t req;
	dci_pwr_t pwr_state;
	logic [31:0] rnd = 32'hcce0fb13;
	int error_cnt = 0;
	int n_checks = 0;
	int row [4];
	bit opn [4];
	int mrg [4];
	// ==========
	// clock, model and design
	always #50 clk = ~clk;
	dci_ctl_model m (.ck(ck), .ck_n(ck_n), .p(p));
	dci_front uut (.clk(clk), .srst(srst), .ck(ck), .ck_n(ck_n),
		.cs_n(p.cs_n), .ras_n(p.ras_n), .cas_n(p.cas_n), .we_n(p.we_n),
		.cke(p.cke), .termination_ctl(tctl), .ba(p.ba), .addr(p.addr),
		.req(req), .req_valid(req_valid), .open_row(open_row),
		.bank_open(bank_open), .base_mode_reg(mr[0]), .ext_mode_reg_1(mr[1]),
		.ext_mode_reg_2(mr[2]), .ext_mode_reg_3(mr[3]),
		.pwr_state(pwr_state), .clocking_on(), .cmd_rx_en(), .clk_rx_en(),
		.term_rx_en(), .out_clk());
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	task automatic chk(input string n, input logic [31:0] s, e);
		n_checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("wrong value %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude();
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// send one command, await the pulse, update and compare the reference
	task automatic cmd(input dci_cmd_t c, input logic [3:0] code,
		input logic [2:0] b, input logic [13:0] a, input int md);
		int k;
		@(negedge clk);
		rnd = lfsr(rnd);
		tctl = rnd[0];
		m.send(code, b, a);
		for (k = 0; k < 8 && req_valid !== 1'b1; k++)
			@(negedge clk);
		if (md != 2) chk("valid", k < 8, md == 1);
		if (md == 1 && k == 8) conclude();
		if (md == 1) chk("req", {req.cmd, req.ba, req.addr}, {c, b, a});
		if (md == 1 && c == DCI_CMD_ACT) row[b[1:0]] = a;
		if (md == 1 && c == DCI_CMD_ACT) opn[b[1:0]] = 1'b1;
		for (int i = 0; i < 4; i++)
			if (md == 1 && (c == DCI_CMD_PRE || c inside {DCI_CMD_RD,
				DCI_CMD_WR} && a[10]) && (i == b[1:0] || c == DCI_CMD_PRE && a[10]))
				opn[i] = 1'b0;
		if (md == 1 && c == DCI_CMD_LMR && !b[2]) mrg[b[1:0]] = a;
		repeat (4) @(negedge clk);
		for (int i = 0; i < 4; i++)
		begin
			chk("open", bank_open[i], opn[i]);
			if (opn[i]) chk("row", open_row[i], row[i]);
			chk("mode", mr[i], mrg[i]);
		end
	endtask
	task automatic wst(input dci_pwr_t s);
		int k;
		for (k = 0; k < 20 && pwr_state !== s; k++)
			@(negedge clk);
		chk("pwr", pwr_state, s);
		if (k == 20) conclude();
	endtask
	// main sequence
	initial
	begin
		repeat (2) @(negedge clk);
		srst = 1'b0;
		wst(DCI_PW_ACTIVE);
		for (int i = 0; i < 4; i++)
			cmd(DCI_CMD_ACT, 4'h3, i[2:0], rnd[13:0], 1);
		cmd(DCI_CMD_RD, 4'h5, 3'h0, 14'h0400 | rnd[9:0], 1);
		cmd(DCI_CMD_WR, 4'h4, 3'h1, {4'h0, rnd[9:0]}, 1);
		cmd(DCI_CMD_PRE, 4'h2, 3'h2, 14'h0000, 1);
		cmd(DCI_CMD_ACT, 4'hb, 3'h2, rnd[13:0], 0);
		for (int i = 0; i < 5; i++)
			cmd(DCI_CMD_LMR, 4'h0, i[2:0], rnd[13:0], i < 4 ? 1 : 2);
		m.cke_cmd = 1'b0;
		cmd(DCI_CMD_NOP, 4'h7, 3'h0, 14'h0, 2);
		wst(DCI_PW_ACT_PD);
		cmd(DCI_CMD_ACT, 4'h3, 3'h0, 14'h0, 0);
		m.cke_cmd = 1'b1;
		cmd(DCI_CMD_NOP, 4'hf, 3'h0, 14'h0, 2);
		wst(DCI_PW_ACTIVE);
		cmd(DCI_CMD_PRE, 4'h2, 3'h1, 14'h0400, 1);
		m.cke_cmd = 1'b0;
		cmd(DCI_CMD_NOP, 4'h7, 3'h0, 14'h0, 2);
		wst(DCI_PW_PRE_PD);
		cmd(DCI_CMD_SREF, 4'h1, 3'h0, 14'h0, 2);
		m.cke_cmd = 1'b1;
		cmd(DCI_CMD_NOP, 4'hf, 3'h0, 14'h0, 2);
		wst(DCI_PW_ACTIVE);
		m.cke_cmd = 1'b0;
		cmd(DCI_CMD_SREF, 4'h1, 3'h0, 14'h0, 2);
		wst(DCI_PW_SELF_REF);
		// wake with the link clock stopped
		m.cke_cmd = 1'b1;
		m.p.cke = 1'b1;
		wst(DCI_PW_ACTIVE);
		conclude();
	end
endmodule
